/* File: rtl/drs_steering.sv */
// design: dma request steering register, pending counters, fifo and ack engine
`timescale 1ns/10ps

module drs_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two of at least 2");
    end

    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic          full_q;
    logic          empty_q;
    logic          push;
    logic          pop;
    logic [CW-1:0] cnt_d;

    assign in_ready  = !full_q;
    assign out_valid = !empty_q;
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;
    assign push      = in_valid && !full_q;
    assign pop       = out_ready && !empty_q;

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_q    <= '0;
            rd_q    <= '0;
            cnt_q   <= '0;
            full_q  <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            if (push) begin
                wr_q <= wr_q + PW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + PW'(1);
            end
            cnt_q   <= cnt_d;
            full_q  <= (cnt_d == CW'(DEPTH));
            empty_q <= (cnt_d == '0);
        end
    end
endmodule

module drs_chan (
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire drs_pkg::drs_chan_cfg_type cfg,
    input  wire logic                      clear,
    input  wire logic                      req,
    input  wire logic                      last_mark,
    input  wire logic                      served,
    input  wire logic                      term,
    output logic [drs_pkg::PEND_W-1:0]     pending_q,
    output logic [drs_pkg::PEND_W-1:0]     last_pos_q,
    output logic                           overflow_q
);
    localparam int PW = drs_pkg::PEND_W;
    logic          en_q;
    logic          wipe;
    logic          inc;
    logic [PW-1:0] pend_d;

    // a new request is lost at saturation rather than wrapping
    assign inc  = req && cfg.enable && (pending_q != drs_pkg::PEND_MAX);
    assign wipe = clear || (cfg.enable && !en_q) || term;

    always_comb begin
        pend_d = pending_q;
        if (inc && !served) begin
            pend_d = pending_q + PW'(1);
        end else if (served && !inc && pending_q != '0) begin
            pend_d = pending_q - PW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            en_q <= 1'b0;
        end else begin
            en_q <= cfg.enable;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pending_q <= '0;
        end else if (wipe) begin
            pending_q <= '0;
        end else begin
            pending_q <= pend_d;
        end
    end

    // position of the last request, counted down as earlier ones are served
    always_ff @(posedge clk) begin
        if (!resetn) begin
            last_pos_q <= '0;
        end else if (wipe) begin
            last_pos_q <= '0;
        end else if (last_mark && inc) begin
            last_pos_q <= pend_d;
        end else if (served && last_pos_q != '0) begin
            last_pos_q <= last_pos_q - PW'(1);
        end
    end

    // sticky; a new overflow wins over the clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            overflow_q <= 1'b0;
        end else if (req && cfg.enable && cfg.overflow_irq_en
                     && pending_q == drs_pkg::PEND_MAX && !served) begin
            overflow_q <= 1'b1;
        end else if (clear) begin
            overflow_q <= 1'b0;
        end
    end
endmodule

module drs_steering #(
    parameter int NIBBLE = 0,
    parameter int DEPTH  = drs_pkg::FIFO_DEPTH
) (
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire logic                          reg_sel,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [3:0]                    reg_be,
    input  wire logic [drs_pkg::DATA_W-1:0]    reg_wdata,
    output logic [drs_pkg::DATA_W-1:0]         reg_rdata_q,
    input  wire logic                          device_request_in,
    input  wire logic                          device_status_in,
    input  wire logic [drs_pkg::DATA_W-1:0]    device_read_data,
    output logic                               device_acknowledge_out,
    output logic                               dma_control_out,
    output logic [drs_pkg::DATA_W-1:0]         device_write_data,
    input  wire drs_pkg::drs_chan_cfg_type     chan_cfg [drs_pkg::NUM_CH],
    input  wire logic [drs_pkg::NUM_CH-1:0]    chan_clear,
    input  wire logic [drs_pkg::NUM_CH-1:0]    software_request,
    input  wire logic                          mem_rd_valid,
    input  wire logic [drs_pkg::DATA_W-1:0]    mem_rd_data,
    output logic                               mem_rd_ready,
    output logic                               mem_wr_valid,
    output logic [drs_pkg::DATA_W-1:0]         mem_wr_data,
    input  wire logic                          mem_wr_ready,
    output logic [drs_pkg::PEND_W-1:0]         pending_count [drs_pkg::NUM_CH],
    output logic [drs_pkg::NUM_CH-1:0]         overflow_irq
);
    localparam int NC = drs_pkg::NUM_CH;
    localparam int DW = drs_pkg::DATA_W;
    localparam int LW = $clog2(DEPTH+1);

    if (NIBBLE < 0 || NIBBLE >= drs_pkg::NUM_NIB) begin : g_chk
        $error("NIBBLE must select one of the eight data nibbles");
    end

    drs_pkg::drs_steer_type      steer_q;
    drs_pkg::drs_eng_state_type  state_q;
    logic [1:0]                  srv_q;
    logic [drs_pkg::CNT_W-1:0]   items_q;
    logic                        go_q;
    logic                        ack_q;
    logic                        ctl_q;
    logic [DW-1:0]               wdat_q;
    logic [drs_pkg::PEND_W-1:0]  last_pos [NC];
    logic [NC-1:0]               ovf;
    logic [NC-1:0]               req_v;
    logic [NC-1:0]               last_v;
    logic [NC-1:0]               ok;
    logic [NC-1:0]               served;
    logic [NC-1:0]               term;
    drs_pkg::drs_chan_cfg_type   cs;
    logic [3:0]                  wnib;
    logic                        wlane;
    logic                        m2d;
    logic                        go;
    logic                        fin;
    logic                        last_fin;
    logic                        steered;
    logic                        pick_v;
    logic [1:0]                  pick;
    logic                        f_in_valid;
    logic                        f_in_ready;
    logic [DW-1:0]               f_in_data;
    logic                        f_out_valid;
    logic                        f_out_ready;
    logic [DW-1:0]               f_out_data;
    logic [LW-1:0]               f_level;

    // register port: the register lives on one nibble of the data bus
    assign wnib  = reg_wdata[NIBBLE*4 +: 4];
    assign wlane = reg_be[NIBBLE/2];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            steer_q <= drs_pkg::STEER_RESET;
        end else if (reg_sel && reg_wr && wlane) begin
            steer_q.enable   <= wnib[drs_pkg::EN_BIT];
            steer_q.chan_sel <= wnib[drs_pkg::SEL_LSB +: drs_pkg::SEL_W];
        end
    end

    // other nibbles and the reserved bit read as zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata_q <= '0;
        end else if (reg_sel && reg_rd) begin
            reg_rdata_q <= DW'({1'b0, steer_q.chan_sel, steer_q.enable}) << (NIBBLE*4);
        end
    end

    // request qualification per channel
    always_comb begin
        for (int i = 0; i < NC; i++) begin
            ok[i]     = chan_cfg[i].enable && chan_cfg[i].initialized;
            req_v[i]  = ok[i] && (software_request[i]
                        || (device_request_in && steer_q.enable
                            && steer_q.chan_sel == 2'(i)));
            last_v[i] = device_request_in && device_status_in && steer_q.enable
                        && steer_q.chan_sel == 2'(i)
                        && !chan_cfg[i].aux_handshake_disable
                        && !chan_cfg[i].block_mode;
            served[i] = fin && srv_q == 2'(i);
            term[i]   = last_fin && srv_q == 2'(i);
        end
    end

    for (genvar g = 0; g < NC; g++) begin : g_ch
        drs_chan u_chan (
            .clk        (clk),
            .resetn     (resetn),
            .cfg        (chan_cfg[g]),
            .clear      (chan_clear[g]),
            .req        (req_v[g]),
            .last_mark  (last_v[g]),
            .served     (served[g]),
            .term       (term[g]),
            .pending_q  (pending_count[g]),
            .last_pos_q (last_pos[g]),
            .overflow_q (ovf[g])
        );
    end
    assign overflow_irq = ovf;

    // lowest numbered ready channel with work is served first
    always_comb begin
        pick_v = 1'b0;
        pick   = 2'h0;
        for (int i = NC - 1; i >= 0; i--) begin
            if (ok[i] && pending_count[i] != '0) begin
                pick_v = 1'b1;
                pick   = 2'(i);
            end
        end
    end

    assign cs      = chan_cfg[srv_q];
    assign m2d     = !cs.to_memory;
    assign steered = steer_q.enable && steer_q.chan_sel == srv_q;
    // room counts the item whose data lands at the edge that ends its ack
    assign go = state_q == drs_pkg::ENG_XFER && ok[srv_q]
                && (m2d ? f_out_valid : (LW'(32'(f_level) + 32'(go_q)) < LW'(DEPTH)));
    assign fin      = go && items_q <= drs_pkg::CNT_W'(1);
    assign last_fin = fin && last_pos[srv_q] == drs_pkg::PEND_W'(1)
                      && !cs.aux_handshake_disable && !cs.block_mode;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= drs_pkg::ENG_IDLE;
            srv_q   <= 2'h0;
            items_q <= '0;
        end else begin
            case (state_q)
                drs_pkg::ENG_IDLE: begin
                    if (pick_v) begin
                        srv_q   <= pick;
                        items_q <= chan_cfg[pick].block_mode
                                   ? chan_cfg[pick].transfer_count
                                   : drs_pkg::CNT_W'(1);
                        state_q <= drs_pkg::ENG_XFER;
                    end
                end
                drs_pkg::ENG_XFER: begin
                    if (!ok[srv_q] || fin) begin
                        state_q <= drs_pkg::ENG_IDLE;
                    end else if (go) begin
                        items_q <= items_q - drs_pkg::CNT_W'(1);
                    end
                end
                default: state_q <= drs_pkg::ENG_IDLE;
            endcase
        end
    end

    // acknowledge lasts one cycle per item; block mode items can run back to back
    always_ff @(posedge clk) begin
        if (!resetn) begin
            go_q  <= 1'b0;
            ack_q <= 1'b0;
            ctl_q <= 1'b0;
        end else begin
            go_q  <= go && !m2d;
            ack_q <= go && steered;
            ctl_q <= last_fin && steered;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wdat_q <= '0;
        end else if (go && m2d) begin
            wdat_q <= f_out_data;
        end
    end

    assign device_acknowledge_out = ack_q;
    assign dma_control_out        = ctl_q;
    assign device_write_data      = wdat_q;

    // device data is sampled at the edge that ends its acknowledge
    assign f_in_valid  = m2d ? mem_rd_valid : go_q;
    assign f_in_data   = m2d ? mem_rd_data : device_read_data;
    assign f_out_ready = m2d ? go : mem_wr_ready;
    assign mem_rd_ready = m2d && f_in_ready;
    assign mem_wr_valid = !m2d && f_out_valid;
    assign mem_wr_data  = f_out_data;

    drs_fifo #(
        .W     (DW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data),
        .level     (f_level)
    );
endmodule

/* File: shared/drs_pkg.sv */
// package: constants and types of the dma request steering block
package drs_pkg;
    localparam int NUM_CH = 4;
    localparam int DATA_W = 32;
    localparam int NIB_W = 4;
    localparam int NUM_NIB = 8;
    localparam int EN_BIT = 0;
    localparam int SEL_LSB = 1;
    localparam int SEL_W = 2;
    localparam int RSV_BIT = 3;
    localparam int PEND_W = 10;
    localparam logic [9:0] PEND_MAX = 10'h3ff;
    localparam int CNT_W = 16;
    localparam int FIFO_DEPTH = 8;

    typedef struct packed {
        logic [1:0] chan_sel;
        logic       enable;
    } drs_steer_type;

    localparam drs_steer_type STEER_RESET = 3'h0;

    typedef struct packed {
        logic              enable;
        logic              initialized;
        logic              block_mode;
        logic              aux_handshake_disable;
        logic              to_memory;
        logic              overflow_irq_en;
        logic [CNT_W-1:0]  transfer_count;
    } drs_chan_cfg_type;

    typedef enum logic [0:0] {
        ENG_IDLE = 1'b0,
        ENG_XFER = 1'b1
    } drs_eng_state_type;
endpackage

/* File: tb/drs_steering_chk.sv */
// checker: port-level assertions for the request steering block
`timescale 1ns/10ps

module drs_steering_chk #(
    parameter int NIBBLE = 0,
    parameter int DEPTH  = 8
) (
    input wire logic                       clk,
    input wire logic                       resetn,
    input wire logic                       reg_sel,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [3:0]                 reg_be,
    input wire logic [drs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [drs_pkg::DATA_W-1:0] reg_rdata_q,
    input wire logic                       device_request_in,
    input wire logic                       device_acknowledge_out,
    input wire logic                       dma_control_out,
    input wire drs_pkg::drs_chan_cfg_type  chan_cfg [drs_pkg::NUM_CH],
    input wire logic [drs_pkg::NUM_CH-1:0] chan_clear,
    input wire logic [drs_pkg::NUM_CH-1:0] software_request,
    input wire logic                       mem_wr_valid,
    input wire logic [drs_pkg::PEND_W-1:0] pending_count [drs_pkg::NUM_CH],
    input wire logic [drs_pkg::NUM_CH-1:0] overflow_irq
);
    logic                       en_q;
    logic [1:0]                 sel_q;
    drs_pkg::drs_chan_cfg_type  cf;
    logic [drs_pkg::PEND_W-1:0] pend;
    logic                       valid;

    assign cf    = chan_cfg[sel_q];
    assign pend  = pending_count[sel_q];
    assign valid = device_request_in && en_q && cf.enable && cf.initialized;

    // shadow of the steering nibble, followed from register writes
    always_ff @(posedge clk) begin
        if (!resetn) begin
            en_q  <= 1'b0;
            sel_q <= 2'h0;
        end else if (reg_sel && reg_wr && reg_be[NIBBLE/2]) begin
            en_q  <= reg_wdata[NIBBLE*4];
            sel_q <= reg_wdata[NIBBLE*4+1 +: 2];
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_lone_req;
        valid && pend == 10'h0 && !device_acknowledge_out && !cf.block_mode;
    endsequence
    sequence s_quiet2;
        !device_acknowledge_out ##1 !device_acknowledge_out;
    endsequence

    a_read_back: assert property (reg_sel && reg_rd && !reg_wr |=>
        reg_rdata_q == ({29'h0, sel_q, en_q} << (4 * NIBBLE)))
        else $error("read data differs from steering state");
    a_no_count_off: assert property (!en_q && software_request == 4'h0 && !reg_wr
        |=> pend <= $past(pend))
        else $error("request counted while steering disabled");
    a_count_req: assert property (valid && software_request == 4'h0 && !reg_wr
        && !chan_clear[sel_q] && !cf.block_mode && pend != drs_pkg::PEND_MAX
        && $past(cf.enable) |=> (dma_control_out ? pend == 10'h0
        : pend == $past(pend) + (device_acknowledge_out ? 10'h0 : 10'h1)))
        else $error("pending count did not step by one");
    a_overflow_set: assert property (valid && pend == drs_pkg::PEND_MAX
        && cf.overflow_irq_en && !reg_wr |=> overflow_irq[sel_q] || device_acknowledge_out)
        else $error("overflow not raised at full count");
    a_clear_zero: assert property (chan_clear[sel_q] && !reg_wr |=> pend == 10'h0)
        else $error("clear left pending nonzero");
    a_enable_clear: assert property ($rose(chan_cfg[2].enable)
        |=> pending_count[2] == 10'h0)
        else $error("channel enable left pending nonzero");
    a_ctl_with_ack: assert property (dma_control_out |-> device_acknowledge_out
        && !cf.aux_handshake_disable && !cf.block_mode)
        else $error("control output outside a last acknowledge");
    a_wr_after_ack: assert property (device_acknowledge_out && cf.to_memory
        |=> mem_wr_valid)
        else $error("device data not buffered after acknowledge");
    a_lone_req: assert property (s_lone_req |=> s_quiet2)
        else $error("acknowledge too soon after request");
endmodule

/* File: tb/drs_fabric_dev.sv */
// fabric device model: raises requests and serves data on acknowledge
`timescale 1ns/10ps

module drs_fabric_dev (
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic        ctl,
    input  wire logic [31:0] wdata,
    output logic             req,
    output logic             status,
    output logic [31:0]      rdata
);
    logic [31:0] seq_q = 32'h0;
    logic [31:0] got[$];
    int          ctl_count = 0;

    initial {req, status} = 2'b00;
    // data shown only in the acknowledge cycle, inverted otherwise
    assign rdata = ack ? seq_q : ~seq_q;
    always @(posedge clk) begin
        if (ack) begin
            seq_q <= seq_q + 32'h1;
            got.push_back(wdata);
        end
        if (ack && ctl)
            ctl_count++;
    end

    // n requests on consecutive edges; status marks the final one as last
    task automatic send(input int n, input bit last);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            req = 1'b1;
            status = last && (i == n - 1);
        end
        @(negedge clk);
        {req, status} = 2'b00;
    endtask
endmodule

/* File: tb/tb_top.sv */
// testbench: scenarios for the request steering block
`timescale 1ns/10ps

module tb_top;
    logic        clk = 1'b0, resetn = 1'b0, reg_sel = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0]  reg_be = 4'h0, chan_clear = 4'h0, software_request = 4'h0, overflow_irq;
    logic [31:0] reg_wdata = 32'h0, reg_rdata_q, dev_wdata, dev_rdata, mem_wr_data;
    logic [31:0] mem_rd_data = 32'h0;
    logic        dev_req, dev_stat, ack, ctl, mem_rd_ready, mem_wr_valid;
    logic        mem_rd_valid = 1'b0, mem_wr_ready = 1'b1;
    drs_pkg::drs_chan_cfg_type cfg [drs_pkg::NUM_CH];
    logic [9:0]  pend [drs_pkg::NUM_CH];
    logic [31:0] wq[$];
    int          fail_count = 0, num_checks = 0, acks = 0;

    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (ack)
            acks++;
        if (mem_wr_valid && mem_wr_ready)
            wq.push_back(mem_wr_data);
    end

    drs_steering i_dut (.clk, .resetn, .reg_sel, .reg_wr, .reg_rd, .reg_be, .reg_wdata,
        .reg_rdata_q, .device_request_in(dev_req), .device_status_in(dev_stat),
        .device_read_data(dev_rdata), .device_acknowledge_out(ack), .dma_control_out(ctl),
        .device_write_data(dev_wdata), .chan_cfg(cfg), .chan_clear, .software_request,
        .mem_rd_valid, .mem_rd_data, .mem_rd_ready, .mem_wr_valid, .mem_wr_data,
        .mem_wr_ready, .pending_count(pend), .overflow_irq);
    drs_fabric_dev i_dev (.clk, .ack, .ctl, .wdata(dev_wdata), .req(dev_req),
        .status(dev_stat), .rdata(dev_rdata));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [31:0] d, input logic [3:0] be);
        @(negedge clk);
        {reg_sel, reg_wr, reg_be, reg_wdata} = {2'b11, be, d};
        @(negedge clk);
        {reg_sel, reg_wr} = 2'b00;
    endtask
    task automatic rd(input logic [31:0] exp);
        @(negedge clk);
        {reg_sel, reg_rd} = 2'b11;
        @(negedge clk);
        {reg_sel, reg_rd} = 2'b00;
        chk(reg_rdata_q, exp);
    endtask
    task automatic push(input logic [31:0] d);
        @(negedge clk);
        {mem_rd_valid, mem_rd_data} = {1'b1, d};
        do @(posedge clk); while (mem_rd_ready !== 1'b1);
        @(negedge clk);
        mem_rd_valid = 1'b0;
    endtask

    task automatic t_reg;
        rd(32'h0);
        for (int c = 0; c < 4; c++) begin
            wr({8{1'b0, 2'(c), 1'b1}}, 4'hf);
            rd({29'h0, 2'(c), 1'b1});
        end
        wr(32'h0, 4'he); // lane byte not enabled
        rd(32'h7);
        wr(32'h22, 4'h1);
        rd(32'h2);
    endtask
    task automatic t_d2m;
        logic [31:0] s0;
        cfg[0] = '{enable:1'b1, initialized:1'b1, to_memory:1'b1, default:'0};
        wr(32'h1111_1111, 4'hf);
        {mem_wr_ready, acks, s0} = {1'b0, 32'h0, i_dev.seq_q};
        wq.delete();
        i_dev.send(9, 1'b0);
        cyc(40);
        chk(acks, 8);
        chk(pend[0], 1);
        mem_wr_ready = 1'b1;
        cyc(40);
        chk(acks, 9);
        for (int i = 0; i < 9; i++)
            chk(wq[i], s0 + i);
        chk(pend[0], 0);
    endtask
    task automatic t_last;
        int c0 = i_dev.ctl_count;
        acks = 0;
        i_dev.send(3, 1'b1);
        cyc(30);
        chk(acks, 3);
        chk(i_dev.ctl_count, c0 + 1);
        cfg[0].aux_handshake_disable = 1'b1;
        i_dev.send(2, 1'b1);
        cyc(30);
        chk(i_dev.ctl_count, c0 + 1);
        {cfg[0].block_mode, cfg[0].transfer_count, acks} = {1'b1, 16'h3, 32'h0};
        cfg[0].aux_handshake_disable = 1'b0;
        i_dev.send(1, 1'b1);
        cyc(30);
        chk(acks, 3);
        chk(i_dev.ctl_count, c0 + 1);
        chk(pend[0], 0);
        cfg[0] = '0;
    endtask
    task automatic t_m2d;
        cfg[1] = '{enable:1'b1, initialized:1'b1, default:'0};
        wr(32'h3333_3333, 4'hf);
        push(32'h0000_a5c3);
        push(32'h0000_3c5a);
        i_dev.got.delete();
        acks = 0;
        software_request = 4'h2;
        @(negedge clk);
        software_request = 4'h0;
        i_dev.send(1, 1'b0);
        cyc(30);
        chk(acks, 2);
        chk(i_dev.got.size(), 2);
        chk(i_dev.got[0], 32'h0000_a5c3);
        chk(i_dev.got[1], 32'h0000_3c5a);
    endtask
    task automatic t_pend;
        cfg[2] = '{enable:1'b1, initialized:1'b0, overflow_irq_en:1'b1, default:'0};
        wr(32'h4444_4444, 4'hf);
        i_dev.send(5, 1'b0);
        chk(pend[2], 0);
        wr(32'h5555_5555, 4'hf);
        i_dev.send(2, 1'b0);
        chk(pend[2], 0);
        cfg[2].initialized = 1'b1;
        i_dev.send(1024, 1'b0);
        chk(pend[2], 10'h3ff);
        chk(overflow_irq, 4'h4);
        chan_clear = 4'h4;
        @(negedge clk);
        chan_clear = 4'h0;
        chk(pend[2], 0);
        i_dev.send(3, 1'b0);
        chk(pend[2], 3);
        cfg[2].enable = 1'b0;
        @(negedge clk);
        cfg[2].enable = 1'b1;
        cyc(2);
        chk(pend[2], 0);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        foreach (cfg[i])
            cfg[i] = '0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        t_reg;
        t_d2m;
        t_last;
        t_m2d;
        t_pend;
        end_sim;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_sim;
    end
endmodule

bind drs_steering drs_steering_chk #(.NIBBLE(NIBBLE), .DEPTH(DEPTH)) i_chk (.clk, .resetn,
    .reg_sel, .reg_wr, .reg_rd, .reg_be, .reg_wdata, .reg_rdata_q, .device_request_in,
    .device_acknowledge_out, .dma_control_out, .chan_cfg, .chan_clear, .software_request,
    .mem_wr_valid, .pending_count, .overflow_irq);
